// >>> logic/sbp_pkg.sv
// shared constants for the receive/transmit buffer path
package sbp_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int LEN_W = 4;
	localparam logic [15:0] ADDR_STATUS = 16'h7042;
	localparam logic [15:0] ADDR_MIRROR = 16'h7046;
	localparam logic [15:0] ADDR_RXBUF = 16'h7047;
	localparam logic [15:0] ADDR_TXBUF = 16'h7048;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam int ST_CHAR_DONE = 6;
	localparam int ST_TX_FULL = 5;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCLK_PERIOD_NS = 800;
	localparam int HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	typedef enum {SBP_REG_STATUS, SBP_REG_MIRROR, SBP_REG_RXBUF,
		SBP_REG_TXBUF, SBP_REG_NONE} sbp_reg_t;
endpackage

// >>> logic/sbp_link_if.sv
// signals between the buffer core and the shift register engine
`timescale 1ns/1ns
`default_nettype none
interface sbp_link_if;
	logic load;
	logic [15:0] load_data;
	logic clr;
	logic master;
	logic [3:0] char_msb;
	logic sclk_s;
	logic sin_s;
	logic busy;
	logic done;
	logic [15:0] rx_word;
	modport core(output load, load_data, clr, master, char_msb, sclk_s,
		sin_s, input busy, done, rx_word);
	modport shift(input load, load_data, clr, master, char_msb, sclk_s,
		sin_s, output busy, done, rx_word);
endinterface
`default_nettype wire

// >>> logic/sbp_sync2.sv
// two flip-flop synchroniser for pins
`timescale 1ns/1ns
`default_nettype none
module sbp_sync2 import sbp_pkg::*; #(
	parameter int W = 2
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage is read only by the second
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// >>> logic/sbp_shift.sv
// serial shift register engine, msb out first, lsb in
`timescale 1ns/1ns
`default_nettype none
module sbp_shift import sbp_pkg::*; #(
	parameter int HALF = HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	sbp_link_if.shift lk,
	output logic ser_out,
	output logic sclk_out,
	output logic sclk_oe_n
);
	logic [15:0] sr;
	logic [3:0] cnt;
	logic [7:0] div;
	logic active, in_bit, sclk_d, rise, fall;

	generate
		if (HALF < 1 || HALF > 255) begin : g_chk
			$error("sbp_shift: HALF out of range");
		end
	endgenerate

	// master clock toggles only while a character is active
	always_ff @(posedge sys_clk) begin
		if (!rstn || lk.clr || !active || !lk.master) begin
			div <= 8'h00;
			sclk_out <= 1'b0;
		end else if (div == 8'(HALF - 1)) begin
			div <= 8'h00;
			sclk_out <= ~sclk_out;
		end else begin
			div <= div + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			sclk_d <= 1'b0;
		else
			sclk_d <= lk.master ? sclk_out : lk.sclk_s;
	end

	assign rise = (lk.master ? sclk_out : lk.sclk_s) & ~sclk_d;
	assign fall = ~(lk.master ? sclk_out : lk.sclk_s) & sclk_d;
	assign sclk_oe_n = ~lk.master;
	assign ser_out = sr[15];
	assign lk.busy = active;
	assign lk.rx_word = sr;

	// sample on rise, shift on fall
	always_ff @(posedge sys_clk) begin
		lk.done <= 1'b0;
		if (!rstn || lk.clr) begin
			sr <= DATA_RST;
			cnt <= 4'h0;
			active <= 1'b0;
			in_bit <= 1'b0;
		end else if (lk.load) begin
			sr <= lk.load_data;
			cnt <= 4'h0;
			active <= lk.master;
		end else begin
			if (rise) begin
				in_bit <= lk.sin_s;
				if (!lk.master)
					active <= 1'b1;
			end
			if (fall && active) begin
				sr <= {sr[14:0], in_bit}; // [R13] [R5]
				cnt <= cnt + 4'h1;
				if (cnt == lk.char_msb) begin
					active <= 1'b0;
					cnt <= 4'h0;
					lk.done <= 1'b1;
				end
			end
		end
	end

	shift_in_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R13]
		fall && active && !lk.load && !lk.clr |=>
		sr[0] == $past(in_bit) && sr[15:1] == $past(sr[14:0]))
		else $error("shift register did not take bit at lsb");
endmodule
`default_nettype wire

// >>> logic/sbp_buf.sv
// receive, mirror and transmit holding buffers around the shifter
// What this block does
// [R1] reading the mirror address returns receive data and leaves the char-done flag alone.
// [R2] the mirror always holds the same value as the receive buffer.
// [R3] a finished character goes into both buffers and sets char-done in one cycle.
// [R4] reading the receive buffer address clears the char-done flag.
// [R5] received characters end right-justified, last bit at bit 0.
// [R6] writing the holding buffer during a shift stores it and sets tx-full.
// [R7] at end of a character with tx-full set, the holding buffer loads the shifter and tx-full clears.
// [R8] writing the holding buffer while idle loads the shifter directly, tx-full stays clear.
// [R9] in master mode that idle write starts a transfer.
// [R10] software left-justifies transmit characters; nothing realigns them.
// [R11] char-done with its enable set raises the interrupt request.
// [R12] driving the soft reset control low clears char-done as well.
// [R13] the shifter sends msb first and takes one bit into its lsb per bit sent.
// [R14] system reset zeroes all buffers and clears both flags.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module sbp_buf import sbp_pkg::*; #(
	parameter int HALF = HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic master_mode,
	input wire logic [3:0] char_msb,
	input wire logic char_complete_irq_enable,
	input wire logic soft_reset_control_n,
	output logic irq,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_n,
	input wire logic ser_in,
	output logic ser_out
);

	////////////////////////////////////////////////////////////////
	// state

	logic [15:0] rx_data_buffer;
	logic [15:0] rx_debug_mirror;
	logic [15:0] tx_holding_buffer;
	logic char_done;
	logic tx_full;
	logic [1:0] pin_sync;
	logic wr_tx, rd_rx, idle;
	logic [15:0] next_rdata;
	sbp_reg_t rsel;

	sbp_link_if lk();

	generate
		if (HALF < 1) begin : g_chk
			$error("sbp_buf: HALF must be at least one");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// address decode, used by both read and write paths

	function automatic sbp_reg_t decode(input logic [15:0] a);
		case (a)
			ADDR_STATUS: decode = SBP_REG_STATUS;
			ADDR_MIRROR: decode = SBP_REG_MIRROR;
			ADDR_RXBUF: decode = SBP_REG_RXBUF;
			ADDR_TXBUF: decode = SBP_REG_TXBUF;
			default: decode = SBP_REG_NONE;
		endcase
	endfunction

	assign rsel = decode(reg_addr);
	assign wr_tx = reg_wr && decode(reg_addr) == SBP_REG_TXBUF;
	assign rd_rx = reg_rd && rsel == SBP_REG_RXBUF;
	// a character ending this cycle frees the shifter now
	assign idle = !lk.busy || lk.done;

	////////////////////////////////////////////////////////////////
	// pins

	sbp_sync2 #(.W(2)) u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.d({sclk_in, ser_in}),
		.q(pin_sync)
	);

	assign lk.sclk_s = pin_sync[1];
	assign lk.sin_s = pin_sync[0];
	assign lk.master = master_mode;
	assign lk.char_msb = char_msb;
	// soft reset is a held level, so the shifter stays parked
	assign lk.clr = !soft_reset_control_n; // [R12]

	sbp_shift #(.HALF(HALF)) u_shift (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.lk(lk.shift),
		.ser_out(ser_out),
		.sclk_out(sclk_out),
		.sclk_oe_n(sclk_oe_n)
	);

	////////////////////////////////////////////////////////////////
	// shifter load: queued word first, else an idle write

	always_comb begin
		lk.load = 1'b0;
		lk.load_data = tx_holding_buffer;
		if (lk.done && tx_full) begin
			lk.load = 1'b1; // [R7]
		end else if (wr_tx && idle) begin
			lk.load = 1'b1; // [R8] [R9]
			lk.load_data = reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// transmit holding buffer

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			tx_holding_buffer <= DATA_RST; // [R14]
		else if (wr_tx)
			tx_holding_buffer <= reg_wdata; // [R6]
	end

	// write beside a queued load refills the buffer, so set wins
	always_ff @(posedge sys_clk) begin
		if (!rstn || lk.clr)
			tx_full <= 1'b0; // [R14]
		else if (wr_tx && (!idle || (lk.done && tx_full)))
			tx_full <= 1'b1; // [R6]
		else if (lk.done && tx_full)
			tx_full <= 1'b0; // [R7]
	end

	////////////////////////////////////////////////////////////////
	// receive buffer and its mirror

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rx_data_buffer <= DATA_RST; // [R14]
			rx_debug_mirror <= DATA_RST;
		end else if (lk.done) begin
			rx_data_buffer <= lk.rx_word; // [R3] [R5]
			rx_debug_mirror <= lk.rx_word; // [R2]
		end
	end

	// new character beats a read clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rstn || lk.clr)
			char_done <= 1'b0; // [R12] [R14]
		else if (lk.done)
			char_done <= 1'b1; // [R3]
		else if (rd_rx)
			char_done <= 1'b0; // [R4]
	end

	assign irq = char_done && char_complete_irq_enable; // [R11]

	////////////////////////////////////////////////////////////////
	// register reads, data valid only the cycle after the strobe

	always_comb begin
		next_rdata = DATA_RST;
		case (rsel)
			SBP_REG_STATUS: begin
				next_rdata[ST_CHAR_DONE] = char_done;
				next_rdata[ST_TX_FULL] = tx_full;
			end
			SBP_REG_MIRROR: next_rdata = rx_debug_mirror; // [R1]
			SBP_REG_RXBUF: next_rdata = rx_data_buffer;
			SBP_REG_TXBUF: next_rdata = tx_holding_buffer;
			default: next_rdata = DATA_RST;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn || !reg_rd)
			reg_rdata <= DATA_RST;
		else
			reg_rdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	mirror_equal_a: assert property ( // [R2]
		rx_debug_mirror == rx_data_buffer)
		else $error("mirror differs from receive buffer");

	mirror_keeps_flag_a: assert property ( // [R1]
		reg_rd && rsel == SBP_REG_MIRROR && char_done && !lk.clr
		|=> char_done && reg_rdata == $past(rx_data_buffer))
		else $error("mirror read disturbed char-done");

	rx_capture_a: assert property ( // [R3]
		lk.done && !lk.clr |=>
		rx_data_buffer == $past(lk.rx_word) && char_done)
		else $error("finished character not captured");

	rx_read_clear_a: assert property ( // [R4]
		rd_rx && !lk.done && !lk.clr |=> !char_done)
		else $error("receive read left char-done set");

	tx_full_set_a: assert property ( // [R6]
		wr_tx && !idle && !lk.clr |=>
		tx_full && tx_holding_buffer == $past(reg_wdata))
		else $error("busy write did not set tx-full");

	tx_reload_a: assert property ( // [R7]
		lk.done && tx_full && !wr_tx && !lk.clr |->
		lk.load && lk.load_data == tx_holding_buffer ##1 !tx_full)
		else $error("queued word not loaded at character end");

	// a queued word ending this cycle takes the shifter instead
	fall_through_a: assert property ( // [R8]
		wr_tx && !lk.busy && !(lk.done && tx_full) && !lk.clr |->
		lk.load && lk.load_data == reg_wdata ##1 !tx_full)
		else $error("idle write did not fall through");

	master_start_a: assert property ( // [R9]
		master_mode && wr_tx && !lk.busy && !lk.clr |=> lk.busy)
		else $error("idle master write did not start");

	irq_follow_a: assert property ( // [R11]
		$rose(char_done) && char_complete_irq_enable |-> irq
		##1 (irq || !char_done || !char_complete_irq_enable))
		else $error("interrupt request not raised");

	soft_clear_a: assert property ( // [R12]
		!soft_reset_control_n |=> !char_done && !tx_full && !lk.busy)
		else $error("soft reset left flags set");

	// own disable, the default one would mute the reset antecedent
	reset_zero_a: assert property (@(posedge sys_clk) disable iff (1'b0) // [R14]
		!rstn |=> rx_data_buffer == DATA_RST && !char_done && !tx_full
		&& tx_holding_buffer == DATA_RST && rx_debug_mirror == DATA_RST)
		else $error("system reset left state behind");

	////////////////////////////////////////////////////////////////
	// read data path

	mirror_data_a: assert property ( // [R1]
		reg_rd && rsel == SBP_REG_MIRROR |=>
		reg_rdata == $past(rx_debug_mirror))
		else $error("mirror read returned wrong data");

	rx_data_a: assert property ( // [R4]
		rd_rx |=> reg_rdata == $past(rx_data_buffer))
		else $error("receive read returned wrong data");

	tx_read_a: assert property ( // [R6]
		reg_rd && rsel == SBP_REG_TXBUF |=>
		reg_rdata == $past(tx_holding_buffer))
		else $error("holding buffer read returned wrong data");

	status_bits_a: assert property ( // [R6]
		reg_rd && rsel == SBP_REG_STATUS |=>
		reg_rdata[ST_TX_FULL] == $past(tx_full)
		&& reg_rdata[ST_CHAR_DONE] == $past(char_done))
		else $error("status read returned wrong flags");

	rdata_quiet_a: assert property ( // [R1]
		!reg_rd |=> reg_rdata == DATA_RST)
		else $error("read data stood without a strobe");

	////////////////////////////////////////////////////////////////
	// flags and buffers between events

	mirror_hold_a: assert property ( // [R2]
		!lk.done |=> $stable(rx_debug_mirror))
		else $error("mirror changed without a character");

	done_hold_a: assert property ( // [R3]
		char_done && !rd_rx && !lk.clr |=> char_done)
		else $error("char-done dropped without a clear");

	full_hold_a: assert property ( // [R7]
		tx_full && !lk.done && !lk.clr |=> tx_full)
		else $error("tx-full dropped before character end");

	idle_clear_a: assert property ( // [R8]
		wr_tx && !lk.busy && !lk.done && !tx_full && !lk.clr |=> !tx_full)
		else $error("idle write set tx-full");

	irq_off_a: assert property ( // [R11]
		!char_complete_irq_enable |-> !irq)
		else $error("interrupt request without enable");

	////////////////////////////////////////////////////////////////
	// shifter side

	first_bit_a: assert property ( // [R13]
		lk.load && !lk.clr |=> ser_out == $past(lk.load_data[15]))
		else $error("first bit out is not the msb");

	sclk_idle_a: assert property ( // [R9]
		!lk.busy |=> !sclk_out)
		else $error("link clock moved while idle");

	oe_mode_a: assert property ( // [R9]
		sclk_oe_n == !master_mode)
		else $error("clock enable does not follow mode");

	soft_park_a: assert property ( // [R12]
		!soft_reset_control_n |=> !sclk_out)
		else $error("soft reset left the link clock running");

	cover_rx_done: cover property (lk.done ##1 rd_rx);
	cover_queue: cover property (tx_full ##[1:300] lk.done);
	cover_back2back: cover property (wr_tx ##1 wr_tx);
	cover_mirror_rd: cover property (reg_rd && rsel == SBP_REG_MIRROR
		&& char_done);

	cover_soft: cover property (char_done ##1 !soft_reset_control_n);
endmodule
`default_nettype wire

// >>> tb/sbp_peer.sv
// far-side link device model: slave to our clock, or master with its own
`timescale 1ns/1ns
`default_nettype none
module sbp_peer (
	input wire logic master_mode,
	input wire logic sclk_out,
	input wire logic ser_out,
	output logic sclk_in,
	output logic ser_in
);
	logic [15:0] sreg;
	logic [15:0] prx;
	logic lclk;
	////////////////////////////////////////////////////////////////////////
	// whichever side is master owns the clock
	assign lclk = master_mode ? sclk_out : sclk_in;
	assign ser_in = sreg[15];
	initial begin
		sclk_in = 1'b0;
		sreg = 16'h0000;
		prx = 16'h0000;
	end
	// capture on rise, msb first
	always @(posedge lclk) begin
		prx <= {prx[14:0], ser_out};
	end
	// next bit out on fall, so it is stable a half period before sampling
	always @(negedge lclk) begin
		sreg <= {sreg[14:0], 1'b0};
	end
	////////////////////////////////////////////////////////////////////////
	task automatic load(input logic [15:0] w);
		sreg = w;
	endtask
	// own clock, 800 ns period; odd start offset keeps phase unrelated
	task automatic run(input int nbits);
		#37;
		repeat (nbits) begin
			#400 sclk_in = 1'b1;
			#400 sclk_in = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/sbp_buf_tb.sv
// self-checking bench for the buffer path, master and slave transfers
`timescale 1ns/1ns
`default_nettype none
module sbp_buf_tb;
	import sbp_pkg::*;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic master_mode = 1'b1;
	logic [3:0] char_msb = 4'h7;
	logic irq_en = 1'b1;
	logic soft_n = 1'b1;
	logic [15:0] reg_rdata;
	logic irq, sclk_in, sclk_out, sclk_oe_n, ser_in, ser_out;
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [15:0] exp_q[$];
	logic pend = 1'b0;
	logic [7:0] b1, b2, b3, p1, p2, p3;
	logic [15:0] addrs[5] = '{ADDR_STATUS, ADDR_MIRROR, ADDR_RXBUF,
		ADDR_TXBUF, 16'h7045};
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	sbp_buf sbp_buf_i (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.master_mode(master_mode),
		.char_msb(char_msb),
		.char_complete_irq_enable(irq_en),
		.soft_reset_control_n(soft_n),
		.irq(irq),
		.sclk_in(sclk_in),
		.sclk_out(sclk_out),
		.sclk_oe_n(sclk_oe_n),
		.ser_in(ser_in),
		.ser_out(ser_out)
	);
	sbp_peer sbp_peer_i (
		.master_mode(master_mode),
		.sclk_out(sclk_out),
		.ser_out(ser_out),
		.sclk_in(sclk_in),
		.ser_in(ser_in)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (pend) begin
			chk("reg_rdata", reg_rdata, exp_q.pop_front());
		end
		pend <= reg_rd;
	end
	// one idle cycle between strobes avoids a double drive in one step
	task automatic wr(input logic [15:0] a, d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(exp);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	// polled on the falling edge so irq has settled
	task automatic wait_irq();
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge sys_clk);
			if (irq === 1'b1) break;
		end
		if (irq !== 1'b1) begin
			n_mismatch++;
			test_done();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h82fe));
		{b1, b2, b3, p1} = $urandom;
		{p2, p3} = 16'($urandom);
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		foreach (addrs[k]) rd(addrs[k], 16'h0000);
		// master: two words back to back, second one queued
		sbp_peer_i.load({p1, p2});
		wr(ADDR_TXBUF, {b1, 8'h00});
		chk("sclk_oe_n", {15'h0000, sclk_oe_n}, 16'h0000);
		wr(ADDR_TXBUF, {b2, 8'h00});
		rd(ADDR_STATUS, 16'h0020);
		rd(ADDR_TXBUF, {b2, 8'h00});
		wait_irq();
		chk("irq", {15'h0000, irq}, 16'h0001);
		rd(ADDR_STATUS, 16'h0040);
		rd(ADDR_MIRROR, {8'h00, p1});
		rd(ADDR_STATUS, 16'h0040);
		rd(ADDR_RXBUF, {8'h00, p1});
		rd(ADDR_STATUS, 16'h0000);
		wait_irq();
		chk("sclk_out", {15'h0000, sclk_out}, 16'h0000);
		chk("link_rx", sbp_peer_i.prx, {b1, b2});
		rd(ADDR_RXBUF, {8'h00, p2});
		// slave: idle write falls through, far side clocks the frame
		@(posedge sys_clk);
		master_mode <= 1'b0;
		sbp_peer_i.load({p3, 8'h00});
		wr(ADDR_TXBUF, {b3, 8'h00});
		chk("sclk_oe_n", {15'h0000, sclk_oe_n}, 16'h0001);
		rd(ADDR_STATUS, 16'h0000);
		sbp_peer_i.run(8);
		wait_irq();
		chk("link_rx", {8'h00, sbp_peer_i.prx[7:0]}, {8'h00, b3});
		rd(ADDR_MIRROR, {8'h00, p3});
		@(posedge sys_clk);
		soft_n <= 1'b0;
		@(posedge sys_clk);
		soft_n <= 1'b1;
		rd(ADDR_STATUS, 16'h0000);
		@(negedge sys_clk);
		chk("irq", {15'h0000, irq}, 16'h0000);
		repeat (3) @(posedge sys_clk);
		test_done();
	end
endmodule
`default_nettype wire
